// [design/ddpd_ctrl.sv]
`timescale 1ns/1ps
// Controller-side power-down sequencer
module ddpd_ctrl #(
	parameter int CPDED  = ddpd_pkg::CPDED_CYC,
	parameter int XP     = ddpd_pkg::XP_CYC,
	parameter int XPDLL  = ddpd_pkg::XPDLL_CYC,
	parameter int TCKE   = ddpd_pkg::CKE_CYC,
	parameter int DLLK   = ddpd_pkg::DLLK_CYC,
	parameter int PD_MAX = ddpd_pkg::REFI_CYC * ddpd_pkg::PD_REFI_MAX
) (
	// Clock and reset
	input  wire logic                        ref_clk,
	input  wire logic                        rst,
	// User command port
	input  wire logic                        usrValid,
	input  wire logic [3:0]                  usrCmd,
	input  wire logic [2:0]                  usrBa,
	input  wire logic [ddpd_pkg::ADDR_W-1:0] usrAddr,
	output logic                             usrReady,
	// Power-down request and status
	input  wire logic                        pdReq,
	input  wire logic                        pdAnyDll,
	output logic                             inPd,
	output logic                             dllLocked,
	// Link
	ddpd_if.ctrl                             link
);
	typedef enum logic [1:0] {CT_RUN, CT_PD, CT_EXIT, CT_RELOCK} ddpd_cstate_type;

	// CKE must stay low for both tCPDED and tCKE, and high for both tXP and tCKE;
	// one timer loaded with the larger count covers both, at the cost of a cycle or
	// two of idle time when the counts differ
	localparam int PD_MIN = ddpd_pkg::cmax(CPDED, TCKE); // Shortest low pulse
	localparam int XP_MIN = ddpd_pkg::cmax(XP, TCKE);    // Shortest high pulse

	ddpd_cstate_type                 st_reg, st_next;      // Sequencer state
	logic                            cke_reg, cke_next;    // CKE drive
	logic [3:0]                      cmd_reg, cmd_next;    // Command drive
	logic [2:0]                      ba_reg, ba_next;      // Bank drive
	logic [ddpd_pkg::ADDR_W-1:0]     adr_reg, adr_next;    // Address drive
	logic [ddpd_pkg::CNT_W-1:0]      busy_reg, busy_next;  // MRS/ZQ/RD/WR
	logic [ddpd_pkg::CNT_W-1:0]      dll_reg, dll_next;    // DLL locking
	logic [ddpd_pkg::CNT_W-1:0]      tmr_reg, tmr_next;    // tCKE/tXP
	logic [ddpd_pkg::CNT_W-1:0]      pd_reg, pd_next;      // Time in PD
	logic [ddpd_pkg::CNT_W-1:0]      rd_reg, rd_next;      // tXPDLL block
	logic [ddpd_pkg::BANKS-1:0]      bank_reg, bank_next;  // Open banks
	logic                            a12_reg, a12_next;    // Mirrored MR0 A12
	logic                            rl_reg, rl_next;      // Unlocked entry
	logic                            pdGo;                 // Entry allowed now
	logic                            rdLike;               // Needs locked DLL
	logic                            take;                 // User command taken

	// Step a timer towards zero and park it there
	function automatic logic [ddpd_pkg::CNT_W-1:0] countDown(
		input logic [ddpd_pkg::CNT_W-1:0] v);
		countDown = (v != '0) ? v - 1'b1 : v;
	endfunction

	// Entry blocked by MRS, ZQ, bursts and DLL lock; row ops may overlap
	// pdAnyDll trades a slower, relocking exit for an earlier entry
	assign pdGo   = pdReq && (busy_reg == '0)
		&& ((dll_reg == '0) || pdAnyDll) && (tmr_reg == '0); // RULE2 RULE3 RULE4
	// Reads wait for tXPDLL and any DLL relock RULE5 RULE11
	assign rdLike = (usrCmd == ddpd_pkg::CMD_RD) && ((rd_reg != '0) || (dll_reg != '0));
	assign usrReady = (st_reg == CT_RUN) && !pdGo && (tmr_reg == '0) && !rdLike;
	assign take     = usrValid && usrReady;

	// Next state: command issue, entry, stay and exit
	always_comb begin
		st_next   = st_reg;
		cke_next  = cke_reg;
		cmd_next  = ddpd_pkg::CMD_NOP;
		ba_next   = ba_reg;
		adr_next  = adr_reg;
		// All timers but the time-in-PD count run down on their own and rest at zero
		busy_next = countDown(busy_reg);
		dll_next  = countDown(dll_reg);
		tmr_next  = countDown(tmr_reg);
		rd_next   = countDown(rd_reg);
		pd_next   = pd_reg;
		bank_next = bank_reg;
		a12_next  = a12_reg;
		rl_next   = rl_reg;
		case (st_reg)
			CT_RUN: begin
				// Entry wins over a waiting user command; usrReady drops with pdGo,
				// so a request is never half taken at the entry edge
				if (pdGo) begin
					// CKE falls with a NOP on the same edge RULE1 RULE8
					st_next  = CT_PD;
					cke_next = 1'b0;
					tmr_next = ddpd_pkg::CNT_W'(PD_MIN);
					pd_next  = '0;
					rl_next  = (dll_reg != '0); // RULE5
				end else if (take) begin
					// Pass the user command through, tracking side effects
					cmd_next = usrCmd;
					ba_next  = usrBa;
					adr_next = usrAddr;
					case (usrCmd)
						// Opening a row marks its bank, so the exit speed can be foreseen
						ddpd_pkg::CMD_ACT: bank_next[usrBa] = 1'b1;
						// Precharge closes one bank, or all with the all-banks bit
						ddpd_pkg::CMD_PRE: begin
							if (usrAddr[ddpd_pkg::A_ALLBK])
								bank_next = '0;
							else
								bank_next[usrBa] = 1'b0;
						end
						// Mode register write: mirror the DLL mode bit and start a
						// relock when the DLL reset bit is set
						ddpd_pkg::CMD_MRS: begin
							busy_next = ddpd_pkg::CNT_W'(ddpd_pkg::MRD_CYC);
							if (usrBa == 3'h0) begin
								a12_next = usrAddr[ddpd_pkg::A_PDDLL];
								if (usrAddr[ddpd_pkg::A_DLLRST])
									dll_next = ddpd_pkg::CNT_W'(DLLK);
							end
						end
						// Calibration holds entry off for its whole run
						ddpd_pkg::CMD_ZQ:
							busy_next = ddpd_pkg::CNT_W'(ddpd_pkg::ZQ_CYC);
						// Bursts must drain before CKE may fall
						ddpd_pkg::CMD_RD, ddpd_pkg::CMD_WR:
							busy_next = ddpd_pkg::CNT_W'(ddpd_pkg::RW_CYC);
						// Refresh, NOP and the rest leave no state here
						default: begin
						end
					endcase
				end
			end
			// Powered down: CKE low, only NOPs on the bus
			CT_PD: begin
				// NOPs through tCPDED and tCKE low, capped at nine intervals
				pd_next = pd_reg + 1'b1;
				if ((tmr_reg <= 1)
					&& (!pdReq || (pd_reg >= ddpd_pkg::CNT_W'(PD_MAX - 1)))) begin // RULE8 RULE12 RULE13
					st_next  = CT_EXIT;
					cke_next = 1'b1; // RULE12
					tmr_next = ddpd_pkg::CNT_W'(XP_MIN); // RULE10 RULE14
					// Slow exit when the memory stopped its DLL RULE11
					if ((bank_reg == '0) && !a12_reg)
						rd_next = ddpd_pkg::CNT_W'(XPDLL);
				end
			end
			// Waking: CKE high again
			CT_EXIT: begin
				// CKE held high with NOPs for tXP and tCKE
				// An unlocked entry detours through a DLL reset before running
				if (tmr_reg <= 1)
					st_next = rl_reg ? CT_RELOCK : CT_RUN;
			end
			CT_RELOCK: begin
				// DLL reset after an unlocked entry RULE5
				// Reads stay refused until the relock count runs out, since a DLL
				// that stopped unlocked cannot be trusted to time read data
				cmd_next  = ddpd_pkg::CMD_MRS;
				ba_next   = 3'h0;
				adr_next  = '0;
				adr_next[ddpd_pkg::A_DLLRST] = 1'b1;
				adr_next[ddpd_pkg::A_PDDLL]  = a12_reg;
				busy_next = ddpd_pkg::CNT_W'(ddpd_pkg::MRD_CYC);
				dll_next  = ddpd_pkg::CNT_W'(DLLK);
				rl_next   = 1'b0;
				st_next   = CT_RUN;
			end
			// Unused code: fall back to the running state
			default: st_next = CT_RUN;
		endcase
	end

	// State registers
	// Reset leaves the link awake: CKE high and NOP, so the memory never sees a
	// power-down edge while the controller is still coming up
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			st_reg   <= CT_RUN;
			cke_reg  <= 1'b1;
			cmd_reg  <= ddpd_pkg::CMD_NOP;
			ba_reg   <= 3'h0;
			adr_reg  <= '0;
			busy_reg <= '0;
			dll_reg  <= '0;
			tmr_reg  <= '0;
			pd_reg   <= '0;
			rd_reg   <= '0;
			bank_reg <= '0;
			a12_reg  <= 1'b0;
			rl_reg   <= 1'b0;
		end else begin
			// Every register follows its next value
			st_reg   <= st_next;
			cke_reg  <= cke_next;
			cmd_reg  <= cmd_next;
			ba_reg   <= ba_next;
			adr_reg  <= adr_next;
			busy_reg <= busy_next;
			dll_reg  <= dll_next;
			tmr_reg  <= tmr_next;
			pd_reg   <= pd_next;
			rd_reg   <= rd_next;
			bank_reg <= bank_next;
			a12_reg  <= a12_next;
			rl_reg   <= rl_next;
		end
	end

	// Link drive comes straight from flops
	assign link.cke  = cke_reg;
	assign link.cmd  = cmd_reg;
	assign link.ba   = ba_reg;
	assign link.addr = adr_reg;
	// Status for the user side
	assign inPd      = (st_reg == CT_PD); // Held in power-down
	// Lock is only tracked by counting; a real DLL would report its own lock
	assign dllLocked = (dll_reg == '0);
endmodule

// [design/ddpd_pkg.sv]
// Summary of operation
// RULE1: Enter power-down on CKE low plus NOP/Deselect
// RULE2: No CKE low during MRS, ZQ, DLL lock, reads/writes; with pdAnyDll set the controller lets CKE fall during DLL lock
// RULE3: Row ops may overlap entry; finished before state
// RULE4: Enter power-down with DLL locked when possible
// RULE5: Unlocked entry needs DLL reset after exit
// RULE6: Closed banks give precharge, open give active mode
// RULE7: Entry turns off buffers except clock, ODT, CKE, reset
// RULE8: NOP/Deselect on CKE fall and through tCPDED
// RULE9: Receivers switch off only after tCPDED expires
// RULE10: Active power-down keeps DLL on, fast exit
// RULE11: Precharge mode, A12 zero: DLL off, slow exit
// RULE12: Exit on CKE high with NOP; hold tCKE
// RULE13: Power-down no longer than nine refresh intervals
// RULE14: Timing parameters held as configurable cycle counts
package ddpd_pkg;
	// Command codes as {csN, rasN, casN, weN}
	localparam logic [3:0] CMD_MRS = 4'h0;
	localparam logic [3:0] CMD_REF = 4'h1;
	localparam logic [3:0] CMD_PRE = 4'h2;
	localparam logic [3:0] CMD_ACT = 4'h3;
	localparam logic [3:0] CMD_WR  = 4'h4;
	localparam logic [3:0] CMD_RD  = 4'h5;
	localparam logic [3:0] CMD_ZQ  = 4'h6;
	localparam logic [3:0] CMD_NOP = 4'h7;
	localparam logic [3:0] CMD_DES = 4'h8;
	// Address bit positions
	localparam int A_DLLRST = 8;
	localparam int A_ALLBK  = 10;
	localparam int A_PDDLL  = 12;
	localparam int ADDR_W   = 13;
	localparam int BANKS    = 8;
	// Timing in ref_clk cycles (20 ns each)
	localparam int CPDED_CYC = 1;
	localparam int XP_CYC    = 3;
	localparam int XPDLL_CYC = 10;
	localparam int CKE_CYC   = 3;
	localparam int ROWOP_CYC = 4;
	localparam int MRD_CYC   = 4;
	localparam int ZQ_CYC    = 64;
	localparam int RW_CYC    = 8;
	localparam int DLLK_CYC  = 512;
	localparam int REFI_CYC  = 390;
	localparam int PD_REFI_MAX = 9;
	localparam int CNT_W     = 16;
	// Power-down mode codes
	localparam logic [1:0] PD_NONE = 2'h0;
	localparam logic [1:0] PD_ACT  = 2'h1;
	localparam logic [1:0] PD_PRE  = 2'h2;

	// Deselect or NOP: the only commands allowed at CKE edges
	function automatic logic isIdleCmd(input logic [3:0] c);
		isIdleCmd = c[3] | (c == CMD_NOP);
	endfunction

	// Larger of two cycle counts
	function automatic int cmax(input int a, input int b);
		cmax = (a > b) ? a : b;
	endfunction
endpackage

// [design/ddpd_if.sv]
`timescale 1ns/1ps
// Command and CKE link between controller and memory
interface ddpd_if;
	logic                          cke;  // Clock enable
	logic [3:0]                    cmd;  // {csN, rasN, casN, weN}
	logic [2:0]                    ba;   // Bank address
	logic [ddpd_pkg::ADDR_W-1:0]   addr; // Row/column/mode address

	modport ctrl (output cke, output cmd, output ba, output addr);
	modport dram (input cke, input cmd, input ba, input addr);
endinterface

// [design/ddpd_dram.sv]
`timescale 1ns/1ps
// Memory-side power-down control
module ddpd_dram #(
	parameter int CPDED = ddpd_pkg::CPDED_CYC,
	parameter int XP    = ddpd_pkg::XP_CYC,
	parameter int XPDLL = ddpd_pkg::XPDLL_CYC,
	parameter int ROWOP = ddpd_pkg::ROWOP_CYC
) (
	// Clock and reset
	input  wire logic       ref_clk,
	input  wire logic       rst,
	// Link
	ddpd_if.dram            link,
	// Status
	output logic [1:0]      pdMode,
	output logic            bufEn,
	output logic            rcvEn,
	output logic            dllOn,
	output logic            cmdOk,
	output logic            dllCmdOk
);
	typedef enum logic [1:0] {DV_RUN, DV_PD, DV_EXIT} ddpd_dstate_type;

	ddpd_dstate_type                 st_reg, st_next;       // Power state
	logic [ddpd_pkg::BANKS-1:0]      bank_reg, bank_next;   // Open banks
	logic                            a12_reg, a12_next;     // PD DLL mode bit
	logic [ddpd_pkg::CNT_W-1:0]      op_reg, op_next;       // Internal row op
	logic [ddpd_pkg::CNT_W-1:0]      tmr_reg, tmr_next;     // tCPDED / tXP
	logic [ddpd_pkg::CNT_W-1:0]      dll_reg, dll_next;     // tXPDLL
	logic [1:0]                      mode_reg, mode_next;   // Settled PD mode
	logic                            buf_reg, buf_next;     // Input buffers
	logic                            rcv_reg, rcv_next;     // Cmd receivers
	logic                            don_reg, don_next;     // DLL running
	logic                            idle;                  // NOP or Deselect

	assign idle = ddpd_pkg::isIdleCmd(link.cmd);

	// Step a timer towards zero and park it there
	function automatic logic [ddpd_pkg::CNT_W-1:0] countDown(
		input logic [ddpd_pkg::CNT_W-1:0] v);
		countDown = (v != '0) ? v - 1'b1 : v;
	endfunction

	// Next state of the power-down sequencer
	always_comb begin
		st_next   = st_reg;
		bank_next = bank_reg;
		a12_next  = a12_reg;
		op_next   = countDown(op_reg);
		tmr_next  = countDown(tmr_reg);
		dll_next  = countDown(dll_reg);
		mode_next = mode_reg;
		buf_next  = buf_reg;
		rcv_next  = rcv_reg;
		don_next  = don_reg;
		case (st_reg)
			DV_RUN: begin
				// Commands only count while CKE is high
				if (link.cke) begin
					case (link.cmd)
						ddpd_pkg::CMD_ACT: begin
							bank_next[link.ba] = 1'b1;
							op_next = ROWOP[ddpd_pkg::CNT_W-1:0];
						end
						ddpd_pkg::CMD_PRE: begin
							if (link.addr[ddpd_pkg::A_ALLBK])
								bank_next = '0;
							else
								bank_next[link.ba] = 1'b0;
							op_next = ROWOP[ddpd_pkg::CNT_W-1:0];
						end
						ddpd_pkg::CMD_REF: op_next = ROWOP[ddpd_pkg::CNT_W-1:0];
						ddpd_pkg::CMD_MRS: begin
							if (link.ba == 3'h0)
								a12_next = link.addr[ddpd_pkg::A_PDDLL];
						end
						default: begin
						end
					endcase
				end else if (idle) begin
					// Entry edge: CKE low with NOP/Deselect RULE1
					st_next  = DV_PD;
					buf_next = 1'b0; // RULE7
					tmr_next = ddpd_pkg::CNT_W'(CPDED);
				end
			end
			DV_PD: begin
				// Receivers stay on until tCPDED is over RULE9
				if (tmr_reg <= 1)
					rcv_next = 1'b0;
				// Mode settles once row ops finish RULE3 RULE6
				if (op_reg == '0) begin
					if (bank_reg != '0) begin
						mode_next = ddpd_pkg::PD_ACT;
						don_next  = 1'b1; // RULE10
					end else begin
						mode_next = ddpd_pkg::PD_PRE;
						don_next  = a12_reg; // RULE11
					end
				end
				// CKE sampled high with NOP/Deselect leaves RULE12
				if (link.cke && idle) begin
					st_next   = DV_EXIT;
					buf_next  = 1'b1;
					rcv_next  = 1'b1;
					mode_next = ddpd_pkg::PD_NONE;
					tmr_next  = ddpd_pkg::CNT_W'(XP);
					// Slow exit only if the DLL was really stopped RULE11
					dll_next  = don_reg ? ddpd_pkg::CNT_W'(XP) : ddpd_pkg::CNT_W'(XPDLL);
					don_next  = 1'b1;
				end
			end
			DV_EXIT: begin
				// Exit latency running; commands are NOPs here
				if (tmr_reg <= 1)
					st_next = DV_RUN;
			end
			default: st_next = DV_RUN;
		endcase
	end

	// State registers
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			st_reg   <= DV_RUN;
			bank_reg <= '0;
			a12_reg  <= 1'b0;
			op_reg   <= '0;
			tmr_reg  <= '0;
			dll_reg  <= '0;
			mode_reg <= ddpd_pkg::PD_NONE;
			buf_reg  <= 1'b1;
			rcv_reg  <= 1'b1;
			don_reg  <= 1'b1;
		end else begin
			st_reg   <= st_next;
			bank_reg <= bank_next;
			a12_reg  <= a12_next;
			op_reg   <= op_next;
			tmr_reg  <= tmr_next;
			dll_reg  <= dll_next;
			mode_reg <= mode_next;
			buf_reg  <= buf_next;
			rcv_reg  <= rcv_next;
			don_reg  <= don_next;
		end
	end

	assign pdMode   = mode_reg;
	assign bufEn    = buf_reg;
	assign rcvEn    = rcv_reg;
	assign dllOn    = don_reg;
	// Exit latencies gate the command windows RULE10 RULE11
	assign cmdOk    = (st_reg == DV_RUN) && (tmr_reg == '0);
	assign dllCmdOk = (st_reg == DV_RUN) && (dll_reg == '0);
endmodule

// [verif/ddpd_sva.sv]
`timescale 1ns/1ps
// Link-side checks of power-down entry, hold and exit
module ddpd_sva (
	// Clock and reset
	input wire logic       ref_clk,
	input wire logic       rst,
	// Link from the controller
	input wire logic       cke,
	input wire logic [3:0] cmd,
	// Memory status
	input wire logic [1:0] pdMode,
	input wire logic       bufEn,
	input wire logic       rcvEn,
	input wire logic       dllOn,
	input wire logic       cmdOk,
	input wire logic       dllCmdOk
);
	// One domain, so clock and reset are given once
	default clocking dc @(posedge ref_clk);
	endclocking
	default disable iff (rst);
	// The falling CKE edge carries an idle command
	property p_enterIdle;
		$fell(cke) |-> (cmd[3] || cmd == ddpd_pkg::CMD_NOP);
	endproperty
	a_enterIdle: assert property (p_enterIdle) else $error("entry without idle command");
	// Controller only sends NOP while CKE is low, which covers tCPDED
	property p_lowNop;
		!cke |-> cmd == ddpd_pkg::CMD_NOP;
	endproperty
	a_lowNop: assert property (p_lowNop) else $error("command while clock enable low");
	// Low CKE is held for the minimum pulse
	property p_lowHold;
		$fell(cke) |-> (!cke)[*3];
	endproperty
	a_lowHold: assert property (p_lowHold) else $error("clock enable low too short");
	// Exit is NOP with CKE high for the exit window
	property p_highHold;
		$rose(cke) |-> (cke && cmd == ddpd_pkg::CMD_NOP)[*3];
	endproperty
	a_highHold: assert property (p_highHold) else $error("exit window broken");
	// Buffers go off one cycle after entry is seen
	property p_bufOff;
		$fell(cke) |=> !bufEn;
	endproperty
	a_bufOff: assert property (p_bufOff) else $error("buffers stayed on");
	// Receivers stay on at entry, then drop after the disable delay
	property p_rcvOff;
		$fell(cke) |-> rcvEn ##[1:3] !rcvEn;
	endproperty
	a_rcvOff: assert property (p_rcvOff) else $error("receiver timing wrong");
	// Exit restores buffers and receivers and clears the power-down mode to none
	property p_wake;
		$rose(cke) |=> bufEn && rcvEn && pdMode == ddpd_pkg::PD_NONE;
	endproperty
	a_wake: assert property (p_wake) else $error("exit did not wake");
	// Commands wait out tXP after exit, but not longer
	property p_cmdLat;
		$rose(cke) |=> !cmdOk ##[1:3] cmdOk;
	endproperty
	a_cmdLat: assert property (p_cmdLat) else $error("exit latency wrong");
	// DLL-off exit keeps reads blocked well past tXP
	property p_slowExit;
		$rose(cke) && pdMode == ddpd_pkg::PD_PRE && !dllOn |=> (!dllCmdOk)[*8];
	endproperty
	a_slowExit: assert property (p_slowExit) else $error("slow exit too fast");
	// DLL kept on means reads are free as soon as any command is
	property p_fastExit;
		$rose(cke) && (pdMode == ddpd_pkg::PD_ACT || dllOn) |=> (cmdOk == dllCmdOk)[*6];
	endproperty
	a_fastExit: assert property (p_fastExit) else $error("fast exit not fast");
	// Main scenarios reached
	c_entry: cover property ($fell(cke));
	c_active: cover property (pdMode == ddpd_pkg::PD_ACT);
	c_slow: cover property ($rose(cke) && pdMode == ddpd_pkg::PD_PRE && !dllOn);
endmodule

// [verif/tb_ddr3_power_down_control.sv]
`timescale 1ns/1ps
// Controller and memory ends joined across the link
module tb_ddr3_power_down_control;
	localparam int PDMAX = 20; // Shortened power-down limit keeps the run short
	logic        ref_clk;      // 50 MHz clock
	logic        rst;          // Synchronous reset
	logic        usrValid;     // User request
	logic [3:0]  usrCmd;       // User command code
	logic [2:0]  usrBa;        // User bank
	logic [12:0] usrAddr;      // User address
	logic        usrReady;     // Request accepted
	logic        pdReq;        // Power-down wanted
	logic        pdAnyDll;     // Allow entry while DLL relocks
	logic        inPd;         // Controller in power-down
	logic        dllLocked;    // Controller view of DLL lock
	logic [1:0]  pdMode;       // Memory power-down mode
	logic        bufEn;        // Memory buffers on
	logic        rcvEn;        // Memory receivers on
	logic        dllOn;        // Memory DLL running
	logic        cmdOk;        // tXP satisfied
	logic        dllCmdOk;     // tXPDLL satisfied
	int          errCount;     // Mismatches
	int          checksDone;   // Comparisons made

	ddpd_if i_ddpd_if ();
	ddpd_ctrl #(.DLLK(8), .PD_MAX(PDMAX)) i_ddpd_ctrl (.ref_clk(ref_clk), .rst(rst),
		.usrValid(usrValid), .usrCmd(usrCmd), .usrBa(usrBa), .usrAddr(usrAddr),
		.usrReady(usrReady), .pdReq(pdReq), .pdAnyDll(pdAnyDll), .inPd(inPd),
		.dllLocked(dllLocked), .link(i_ddpd_if.ctrl));
	ddpd_dram i_ddpd_dram (.ref_clk(ref_clk), .rst(rst), .link(i_ddpd_if.dram),
		.pdMode(pdMode), .bufEn(bufEn), .rcvEn(rcvEn), .dllOn(dllOn), .cmdOk(cmdOk),
		.dllCmdOk(dllCmdOk));
	ddpd_sva i_ddpd_sva (.ref_clk(ref_clk), .rst(rst), .cke(i_ddpd_if.cke),
		.cmd(i_ddpd_if.cmd), .pdMode(pdMode), .bufEn(bufEn), .rcvEn(rcvEn),
		.dllOn(dllOn), .cmdOk(cmdOk), .dllCmdOk(dllCmdOk));

	// Free-running clock
	initial begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end

	// Compare one value and count it
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checksDone++;
		if (seen !== exp) begin
			errCount++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	// Print counts and verdict, then stop
	task automatic summarize();
		$display("checks %0d mismatches %0d", checksDone, errCount);
		if (errCount == 0 && checksDone > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// Hand one command over; entered and left at a falling edge
	task automatic send(input logic [3:0] c, input logic [2:0] b, input logic [12:0] a);
		int n;
		n = 0;
		usrValid = 1'b1;
		usrCmd = c;
		usrBa = b;
		usrAddr = a;
		// Ready is combinational, so it is read where it has settled
		while (!usrReady && n < 100) begin
			@(negedge ref_clk);
			n++;
		end
		chk({15'h0, usrReady}, 16'h1);
		@(negedge ref_clk);
		usrValid = 1'b0;
		// One idle edge, so a following call never re-raises valid in this step
		@(negedge ref_clk);
	endtask

	// Ask for power-down and check the state it settles in
	task automatic enterPd(input logic [1:0] mode, input logic dll, output int nWait);
		nWait = 0;
		pdReq = 1'b1;
		while (!inPd && nWait < 50) begin
			@(negedge ref_clk);
			nWait++;
		end
		// Leave room for a row operation still running at entry
		repeat (ddpd_pkg::ROWOP_CYC + 2) @(negedge ref_clk);
		chk({15'h0, i_ddpd_if.cke}, 16'h0);
		chk({14'h0, pdMode}, {14'h0, mode});
		chk({15'h0, dllOn}, {15'h0, dll});
		chk({14'h0, bufEn, rcvEn}, 16'h0);
	endtask

	// Leave power-down, count blocked cycles, watch for a DLL reset
	task automatic exitPd(output int nC, output int nD, output logic sawRst);
		int n;
		n = 0;
		nC = 0;
		nD = 0;
		sawRst = 1'b0;
		pdReq = 1'b0;
		while (!i_ddpd_if.cke && n < 50) begin
			@(negedge ref_clk);
			n++;
		end
		@(negedge ref_clk);
		repeat (30) begin
			if (!cmdOk) nC++;
			if (!dllCmdOk) nD++;
			if (i_ddpd_if.cmd === ddpd_pkg::CMD_MRS
				&& i_ddpd_if.addr[ddpd_pkg::A_DLLRST] === 1'b1) begin
				sawRst = 1'b1;
			end
			@(negedge ref_clk);
		end
	endtask

	// Idle values on both ends straight after reset
	task automatic checkIdle();
		chk({5'h0, i_ddpd_if.cke, usrReady, inPd, dllLocked, bufEn, rcvEn, dllOn, cmdOk,
			dllCmdOk, pdMode}, 16'h06fc);
	endtask

	// Precharge power-down with the DLL switched off: slow exit, no DLL reset
	task automatic prechargeSlow();
		int   nC;
		int   nD;
		int   nW;
		logic sr;
		send(ddpd_pkg::CMD_MRS, 3'h0, 13'h0000);
		enterPd(ddpd_pkg::PD_PRE, 1'b0, nW);
		exitPd(nC, nD, sr);
		chk(16'(nD - nC), 16'(ddpd_pkg::XPDLL_CYC - ddpd_pkg::XP_CYC));
		chk({15'h0, sr}, 16'h0);
	endtask

	// Precharge power-down with the DLL kept on: fast exit
	task automatic prechargeFast();
		int   nC;
		int   nD;
		int   nW;
		logic sr;
		send(ddpd_pkg::CMD_MRS, 3'h0, 13'h1000);
		enterPd(ddpd_pkg::PD_PRE, 1'b1, nW);
		exitPd(nC, nD, sr);
		chk(16'(nD), 16'(nC));
	endtask

	// Entry while a row is still opening ends in active mode
	task automatic activeEntry();
		int   nC;
		int   nD;
		int   nW;
		logic sr;
		send(ddpd_pkg::CMD_MRS, 3'h0, 13'h0000);
		send(ddpd_pkg::CMD_ACT, 3'h3, 13'h0000);
		enterPd(ddpd_pkg::PD_ACT, 1'b1, nW);
		exitPd(nC, nD, sr);
		chk(16'(nD), 16'(nC));
		chk(16'(nC >= 1 && nC <= ddpd_pkg::XP_CYC), 16'h1);
	endtask

	// A read in flight holds entry off
	task automatic readHolds();
		int   nC;
		int   nD;
		int   nW;
		logic sr;
		send(ddpd_pkg::CMD_RD, 3'h3, 13'h0000);
		enterPd(ddpd_pkg::PD_ACT, 1'b1, nW);
		chk(16'(nW >= ddpd_pkg::RW_CYC - 2), 16'h1);
		exitPd(nC, nD, sr);
	endtask

	// Banks closed, then power-down requested past its limit
	task automatic pdLimit();
		int   nC;
		int   nD;
		int   nW;
		logic sr;
		send(ddpd_pkg::CMD_PRE, 3'h0, 13'h0400);
		enterPd(ddpd_pkg::PD_PRE, 1'b0, nW);
		nW = 0;
		while (inPd && nW < 60) begin
			@(negedge ref_clk);
			nW++;
		end
		pdReq = 1'b0;
		chk(16'(nW + ddpd_pkg::ROWOP_CYC + 2 <= PDMAX + 2), 16'h1);
		exitPd(nC, nD, sr);
	endtask

	// Entry while the DLL relocks needs a DLL reset after exit
	task automatic unlockedEntry();
		int   nC;
		int   nD;
		int   nW;
		logic sr;
		send(ddpd_pkg::CMD_MRS, 3'h0, 13'h0100);
		chk({15'h0, dllLocked}, 16'h0);
		pdAnyDll = 1'b1;
		enterPd(ddpd_pkg::PD_PRE, 1'b0, nW);
		pdAnyDll = 1'b0;
		exitPd(nC, nD, sr);
		chk({15'h0, sr}, 16'h1);
	endtask

	// Main sequence
	initial begin
		errCount = 0;
		checksDone = 0;
		rst = 1'b1;
		usrValid = 1'b0;
		usrCmd = ddpd_pkg::CMD_NOP;
		usrBa = 3'h0;
		usrAddr = 13'h0000;
		pdReq = 1'b0;
		pdAnyDll = 1'b0;
		repeat (10) @(negedge ref_clk);
		rst = 1'b0;
		@(negedge ref_clk);
		checkIdle();
		prechargeSlow();
		prechargeFast();
		activeEntry();
		readHolds();
		pdLimit();
		unlockedEntry();
		summarize();
	end

	// Watchdog sized well beyond the few hundred cycles the tests need
	initial begin
		repeat (3000) @(posedge ref_clk);
		errCount++;
		summarize();
	end
endmodule
